// >>> hdl/gateway_status_ctrl.sv
/*
  Gateway status and mode controller: power-up mode capture, watchdog with
  warm boot, three indicator lamps, AXI4-Lite register slave.
  Assumes fault and activity inputs come from logic on CORE_CLK_IN; the mode
  switch and jumper are asynchronous pins.
*/
// What this block does
// - Init switch at power-up selects firmware update
// - Normal switch at power-up selects operation
// - Operation mode enables serial master commands
// - All three serial interfaces always active
// - Watchdog runs only when jumper enables it
// - Unserviced watchdog warm-boots after programmed ms
// - Update mode holds all lamps on
// - Watchdog failure blinks all lamps, 1 s
// - Fatal fault blinks all lamps, 100 ms
// - No error holds power lamp on
// - Bus-off blinks power lamp, 500 ms
// - Transmit failure blinks power lamp, 100 ms
// - CAN traffic blinks CAN lamp, idle off
// - Serial traffic blinks serial lamp, idle off
`timescale 1ns/1ns
module gateway_status_ctrl #(
  parameter int unsigned MS_CYCLES = gateway_status_pkg::MS_CYCLES
) (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        MODE_SWITCH_NORMAL_IN,
  input  wire logic        WATCHDOG_ENABLE_JUMPER_IN,
  input  wire logic        FATAL_FAULT_IN,
  input  wire logic        CAN_BUS_OFF_IN,
  input  wire logic        CAN_TX_FAIL_IN,
  input  wire logic        ADDR_CLAIM_FAIL_IN,
  input  wire logic        CAN_ACTIVITY_IN,
  input  wire logic        SERIAL_ACTIVITY_IN,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             POWER_ERROR_LAMP_OUT,
  output logic             CAN_ACTIVITY_LAMP_OUT,
  output logic             SERIAL_ACTIVITY_LAMP_OUT,
  output logic             UPDATE_MODE_OUT,
  output logic             OPERATION_MODE_OUT,
  output logic             SERIAL_CMD_ENABLE_OUT,
  output logic [2:0]       SERIAL_IF_ENABLE_OUT,
  output logic             WARM_BOOT_OUT
);

  gateway_status_pkg::mode_t mode_q;
  logic        sw_meta_q;
  logic        sw_sync_q;
  logic        jp_meta_q;
  logic        jp_sync_q;
  logic [1:0]  settle_q;
  logic [31:0] ms_div_q;
  logic        ms_tick;
  logic [9:0]  phase_q;
  logic [15:0] wdt_timeout_q;
  logic [15:0] wdt_cnt_q;
  logic        wdt_run;
  logic        wdt_expire;
  logic        wdt_fail_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_go;
  logic        service_wr;
  logic        fail_clr_wr;
  logic [31:0] status_word;
  logic [1:0]  act_pulse;
  logic [1:0]  act_lamp;

  // Blink phase: first half of each period lit
  function automatic logic blink_on(input logic [9:0] ph, input int unsigned period);
    blink_on = (32'(ph) % period) < (period / 2);
  endfunction

  // Pin synchronisers
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      sw_meta_q <= 1'b0;
      sw_sync_q <= 1'b0;
      jp_meta_q <= 1'b0;
      jp_sync_q <= 1'b0;
    end
    else
    begin
      sw_meta_q <= MODE_SWITCH_NORMAL_IN;
      sw_sync_q <= sw_meta_q;
      jp_meta_q <= WATCHDOG_ENABLE_JUMPER_IN;
      jp_sync_q <= jp_meta_q;
    end
  end

  // Mode chosen once after reset, then held until the next reset
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      mode_q   <= gateway_status_pkg::MODE_CAPTURE;
      settle_q <= 2'h0;
    end
    else
    begin
      case (mode_q)
        gateway_status_pkg::MODE_CAPTURE:
        begin
          if (settle_q == 2'(gateway_status_pkg::SYNC_SETTLE_CYCLES - 1))
          begin
            mode_q <= sw_sync_q ? gateway_status_pkg::MODE_OPERATE
                                : gateway_status_pkg::MODE_UPDATE;
          end
          settle_q <= settle_q + 2'h1;
        end
        gateway_status_pkg::MODE_UPDATE:  mode_q <= gateway_status_pkg::MODE_UPDATE;
        gateway_status_pkg::MODE_OPERATE: mode_q <= gateway_status_pkg::MODE_OPERATE;
        default: mode_q <= gateway_status_pkg::MODE_CAPTURE;
      endcase
    end
  end

  // Millisecond tick and free-running blink phase
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      ms_div_q <= 32'h0;
      phase_q  <= 10'h0;
    end
    else
    begin
      ms_div_q <= ms_tick ? 32'h0 : ms_div_q + 32'h1;
      if (ms_tick)
      begin
        phase_q <= (phase_q == 10'(gateway_status_pkg::PHASE_WRAP_MS - 1)) ? 10'h0 : phase_q + 10'h1;
      end
    end
  end
  assign ms_tick = (ms_div_q == MS_CYCLES - 1);

  // Watchdog
  assign wdt_run    = (mode_q == gateway_status_pkg::MODE_OPERATE) && jp_sync_q;
  assign wdt_expire = wdt_run && ms_tick && (wdt_cnt_q >= wdt_timeout_q - 16'h1);

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      wdt_cnt_q     <= 16'h0;
      WARM_BOOT_OUT <= 1'b0;
      wdt_fail_q    <= 1'b0;
    end
    else
    begin
      WARM_BOOT_OUT <= wdt_expire;
      if (!wdt_run || service_wr || wdt_expire)
      begin
        wdt_cnt_q <= 16'h0;
      end
      else if (ms_tick)
      begin
        wdt_cnt_q <= wdt_cnt_q + 16'h1;
      end
      if (wdt_expire)
      begin
        wdt_fail_q <= 1'b1;
      end
      else if (fail_clr_wr)
      begin
        wdt_fail_q <= 1'b0;
      end
    end
  end

  // Activity lamps: an event while idle lights one blink, events during a blink are ignored, then off when idle
  assign act_pulse = {SERIAL_ACTIVITY_IN, CAN_ACTIVITY_IN};
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_act
      logic [9:0] act_cnt_q;
      always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
      begin
        if (RST_IN)
        begin
          act_cnt_q <= 10'h0;
        end
        else if (act_pulse[i] && act_cnt_q == 10'h0)
        begin
          act_cnt_q <= 10'(gateway_status_pkg::ACTIVITY_PERIOD_MS);
        end
        else if (ms_tick && act_cnt_q != 10'h0)
        begin
          act_cnt_q <= act_cnt_q - 10'h1;
        end
      end
      assign act_lamp[i] = act_cnt_q > 10'(gateway_status_pkg::ACTIVITY_PERIOD_MS / 2);
    end
  endgenerate

  // Lamp drive with fault priority
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      POWER_ERROR_LAMP_OUT     <= 1'b0;
      CAN_ACTIVITY_LAMP_OUT    <= 1'b0;
      SERIAL_ACTIVITY_LAMP_OUT <= 1'b0;
    end
    else if (mode_q == gateway_status_pkg::MODE_UPDATE)
    begin
      POWER_ERROR_LAMP_OUT     <= 1'b1;
      CAN_ACTIVITY_LAMP_OUT    <= 1'b1;
      SERIAL_ACTIVITY_LAMP_OUT <= 1'b1;
    end
    else if (mode_q != gateway_status_pkg::MODE_OPERATE)
    begin
      POWER_ERROR_LAMP_OUT     <= 1'b0;
      CAN_ACTIVITY_LAMP_OUT    <= 1'b0;
      SERIAL_ACTIVITY_LAMP_OUT <= 1'b0;
    end
    else if (wdt_fail_q)
    begin
      POWER_ERROR_LAMP_OUT     <= blink_on(phase_q, gateway_status_pkg::WDT_FAIL_PERIOD_MS);
      CAN_ACTIVITY_LAMP_OUT    <= blink_on(phase_q, gateway_status_pkg::WDT_FAIL_PERIOD_MS);
      SERIAL_ACTIVITY_LAMP_OUT <= blink_on(phase_q, gateway_status_pkg::WDT_FAIL_PERIOD_MS);
    end
    else if (FATAL_FAULT_IN)
    begin
      POWER_ERROR_LAMP_OUT     <= blink_on(phase_q, gateway_status_pkg::FATAL_PERIOD_MS);
      CAN_ACTIVITY_LAMP_OUT    <= blink_on(phase_q, gateway_status_pkg::FATAL_PERIOD_MS);
      SERIAL_ACTIVITY_LAMP_OUT <= blink_on(phase_q, gateway_status_pkg::FATAL_PERIOD_MS);
    end
    else
    begin
      if (CAN_BUS_OFF_IN)
      begin
        POWER_ERROR_LAMP_OUT <= blink_on(phase_q, gateway_status_pkg::BUS_OFF_PERIOD_MS);
      end
      else if (CAN_TX_FAIL_IN)
      begin
        POWER_ERROR_LAMP_OUT <= blink_on(phase_q, gateway_status_pkg::TX_FAIL_PERIOD_MS);
      end
      else if (ADDR_CLAIM_FAIL_IN)
      begin
        POWER_ERROR_LAMP_OUT <= blink_on(phase_q, gateway_status_pkg::ADDR_FAIL_PERIOD_MS);
      end
      else
      begin
        POWER_ERROR_LAMP_OUT <= 1'b1;
      end
      CAN_ACTIVITY_LAMP_OUT    <= act_lamp[0];
      SERIAL_ACTIVITY_LAMP_OUT <= act_lamp[1];
    end
  end

  // Mode and serial enables
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      UPDATE_MODE_OUT       <= 1'b0;
      OPERATION_MODE_OUT    <= 1'b0;
      SERIAL_CMD_ENABLE_OUT <= 1'b0;
      SERIAL_IF_ENABLE_OUT  <= gateway_status_pkg::SERIAL_IF_ALL;
    end
    else
    begin
      UPDATE_MODE_OUT       <= mode_q == gateway_status_pkg::MODE_UPDATE;
      OPERATION_MODE_OUT    <= mode_q == gateway_status_pkg::MODE_OPERATE;
      SERIAL_CMD_ENABLE_OUT <= mode_q == gateway_status_pkg::MODE_OPERATE;
      SERIAL_IF_ENABLE_OUT  <= gateway_status_pkg::SERIAL_IF_ALL;
    end
  end

  // AXI4-Lite write path: address and data in either order
  assign S_AXI_AWREADY = !aw_have_q && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_have_q && !S_AXI_BVALID;
  assign wr_go         = aw_have_q && w_have_q && !S_AXI_BVALID;
  assign service_wr    = wr_go && aw_addr_q == gateway_status_pkg::WDT_SERVICE_ADDR;
  assign fail_clr_wr   = wr_go && aw_addr_q == gateway_status_pkg::STATUS_ADDR && w_strb_q[0]
                         && w_data_q[gateway_status_pkg::ST_WDT_FAIL_BIT];

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h0;
      w_data_q      <= 32'h0;
      w_strb_q      <= 4'h0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= gateway_status_pkg::RESP_OKAY;
      wdt_timeout_q <= gateway_status_pkg::WDT_TIMEOUT_RESET;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_have_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_have_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
      if (wr_go)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= gateway_status_pkg::RESP_OKAY;
        case (aw_addr_q)
          gateway_status_pkg::WDT_TIMEOUT_ADDR:
          begin
            if (w_strb_q[0])
              wdt_timeout_q[7:0] <= w_data_q[7:0];
            if (w_strb_q[1])
              wdt_timeout_q[15:8] <= w_data_q[15:8];
          end
          gateway_status_pkg::WDT_SERVICE_ADDR: ;
          gateway_status_pkg::STATUS_ADDR: ;
          default: S_AXI_BRESP <= gateway_status_pkg::RESP_SLVERR;
        endcase
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Status word
  always_comb
  begin
    status_word = 32'h0;
    status_word[gateway_status_pkg::ST_UPDATE_BIT]    = mode_q == gateway_status_pkg::MODE_UPDATE;
    status_word[gateway_status_pkg::ST_OPERATE_BIT]   = mode_q == gateway_status_pkg::MODE_OPERATE;
    status_word[gateway_status_pkg::ST_JUMPER_BIT]    = jp_sync_q;
    status_word[gateway_status_pkg::ST_WDT_FAIL_BIT]  = wdt_fail_q;
    status_word[gateway_status_pkg::ST_BUS_OFF_BIT]   = CAN_BUS_OFF_IN;
    status_word[gateway_status_pkg::ST_TX_FAIL_BIT]   = CAN_TX_FAIL_IN;
    status_word[gateway_status_pkg::ST_ADDR_FAIL_BIT] = ADDR_CLAIM_FAIL_IN;
    status_word[gateway_status_pkg::ST_FATAL_BIT]     = FATAL_FAULT_IN;
  end

  // AXI4-Lite read path
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0;
      S_AXI_RRESP  <= gateway_status_pkg::RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= gateway_status_pkg::RESP_OKAY;
      case (S_AXI_ARADDR)
        gateway_status_pkg::WDT_TIMEOUT_ADDR: S_AXI_RDATA <= {16'h0, wdt_timeout_q};
        gateway_status_pkg::WDT_SERVICE_ADDR: S_AXI_RDATA <= {16'h0, wdt_cnt_q};
        gateway_status_pkg::STATUS_ADDR:      S_AXI_RDATA <= status_word;
        default:
        begin
          S_AXI_RDATA <= 32'h0;
          S_AXI_RRESP <= gateway_status_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule

// >>> hdl/gateway_status_pkg.sv
/*
  Constants for the gateway status and mode block: register map, field
  positions, reset values and lamp timing.
  Assumes a 10 MHz core clock; counts derive from it.
*/
package gateway_status_pkg;
  // Clock and time base
  localparam int unsigned CLK_FREQ_HZ        = 10_000_000;
  localparam int unsigned MS_PER_S           = 1000;
  localparam int unsigned MS_CYCLES          = CLK_FREQ_HZ / MS_PER_S;
  localparam int unsigned SYNC_SETTLE_CYCLES = 3;

  // Blink periods, whole on-off cycle, in ms
  localparam int unsigned WDT_FAIL_PERIOD_MS = 1000;
  localparam int unsigned FATAL_PERIOD_MS    = 100;
  localparam int unsigned BUS_OFF_PERIOD_MS  = 500;
  localparam int unsigned TX_FAIL_PERIOD_MS  = 100;
  localparam int unsigned ADDR_FAIL_PERIOD_MS = 1000;
  localparam int unsigned ACTIVITY_PERIOD_MS = 100;
  localparam int unsigned PHASE_WRAP_MS      = 1000;

  // Watchdog
  localparam logic [15:0] WDT_TIMEOUT_RESET  = 16'h03e8;

  // Register map, byte addresses
  localparam logic [7:0] WDT_TIMEOUT_ADDR    = 8'h00;
  localparam logic [7:0] WDT_SERVICE_ADDR    = 8'h04;
  localparam logic [7:0] STATUS_ADDR         = 8'h08;

  // Status fields
  localparam int unsigned ST_UPDATE_BIT      = 0;
  localparam int unsigned ST_OPERATE_BIT     = 1;
  localparam int unsigned ST_JUMPER_BIT      = 2;
  localparam int unsigned ST_WDT_FAIL_BIT    = 3;
  localparam int unsigned ST_BUS_OFF_BIT     = 4;
  localparam int unsigned ST_TX_FAIL_BIT     = 5;
  localparam int unsigned ST_ADDR_FAIL_BIT   = 6;
  localparam int unsigned ST_FATAL_BIT       = 7;

  // Serial interfaces, all three always on
  localparam logic [2:0] SERIAL_IF_ALL       = 3'h7;

  localparam logic [1:0] RESP_OKAY           = 2'h0;
  localparam logic [1:0] RESP_SLVERR         = 2'h2;

  typedef enum logic [2:0]
  {
    MODE_CAPTURE = 3'h1,
    MODE_UPDATE  = 3'h2,
    MODE_OPERATE = 3'h4
  } mode_t;
endpackage

// >>> verification/gateway_status_monitor.sv
/* Checker for the gateway status block: modes, lamps and watchdog.
   Bound to gateway_status_ctrl; sees its ports only. */
`timescale 1ns/1ns
module gateway_status_monitor #(
  parameter int unsigned MS_CYCLES = 10
) (
  input wire logic       CORE_CLK_IN,
  input wire logic       RST_IN,
  input wire logic       WATCHDOG_ENABLE_JUMPER_IN,
  input wire logic       FATAL_FAULT_IN,
  input wire logic       POWER_ERROR_LAMP_OUT,
  input wire logic       CAN_ACTIVITY_LAMP_OUT,
  input wire logic       SERIAL_ACTIVITY_LAMP_OUT,
  input wire logic       UPDATE_MODE_OUT,
  input wire logic       OPERATION_MODE_OUT,
  input wire logic       SERIAL_CMD_ENABLE_OUT,
  input wire logic [2:0] SERIAL_IF_ENABLE_OUT,
  input wire logic       WARM_BOOT_OUT
);
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (RST_IN);
  AST_IF_ALL: assert property (SERIAL_IF_ENABLE_OUT == 3'h7)
    else $error("Serial interfaces not all on");
  AST_CMD_OP: assert property (SERIAL_CMD_ENABLE_OUT == OPERATION_MODE_OUT)
    else $error("Command enable differs from mode");
  AST_MODE_EXCL: assert property (!(UPDATE_MODE_OUT && OPERATION_MODE_OUT))
    else $error("Both modes on");
  AST_MODE_HOLD: assert property ((UPDATE_MODE_OUT || OPERATION_MODE_OUT) |=>
    $stable({UPDATE_MODE_OUT, OPERATION_MODE_OUT}))
    else $error("Mode changed without reset");
  AST_UPD_LAMPS: assert property (UPDATE_MODE_OUT [*2] |->
    POWER_ERROR_LAMP_OUT && CAN_ACTIVITY_LAMP_OUT && SERIAL_ACTIVITY_LAMP_OUT)
    else $error("Lamp off in update mode");
  AST_FATAL_ALL: assert property ((OPERATION_MODE_OUT && FATAL_FAULT_IN) [*2] |->
    POWER_ERROR_LAMP_OUT == CAN_ACTIVITY_LAMP_OUT && CAN_ACTIVITY_LAMP_OUT == SERIAL_ACTIVITY_LAMP_OUT)
    else $error("Lamps not together on fatal fault");
  AST_WDT_OFF: assert property ((!WATCHDOG_ENABLE_JUMPER_IN) [*6] |-> !WARM_BOOT_OUT)
    else $error("Warm boot with jumper off");
  AST_BOOT_PULSE: assert property (WARM_BOOT_OUT |=> !WARM_BOOT_OUT)
    else $error("Warm boot longer than one cycle");
  AST_BOOT_OP: assert property (WARM_BOOT_OUT |-> OPERATION_MODE_OUT)
    else $error("Warm boot outside operation");
endmodule

bind gateway_status_ctrl gateway_status_monitor #(.MS_CYCLES(MS_CYCLES)) u_monitor (
  .CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .WATCHDOG_ENABLE_JUMPER_IN(WATCHDOG_ENABLE_JUMPER_IN),
  .FATAL_FAULT_IN(FATAL_FAULT_IN), .POWER_ERROR_LAMP_OUT(POWER_ERROR_LAMP_OUT),
  .CAN_ACTIVITY_LAMP_OUT(CAN_ACTIVITY_LAMP_OUT), .SERIAL_ACTIVITY_LAMP_OUT(SERIAL_ACTIVITY_LAMP_OUT),
  .UPDATE_MODE_OUT(UPDATE_MODE_OUT), .OPERATION_MODE_OUT(OPERATION_MODE_OUT),
  .SERIAL_CMD_ENABLE_OUT(SERIAL_CMD_ENABLE_OUT), .SERIAL_IF_ENABLE_OUT(SERIAL_IF_ENABLE_OUT),
  .WARM_BOOT_OUT(WARM_BOOT_OUT));

// >>> verification/lamp_panel_model.sv
/* Panel model: mode switch, watchdog jumper and lamp run timer.
   Settings come from the bench; one lamp is timed per clock. */
`timescale 1ns/1ns
module lamp_panel_model (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        lamp_in,
  input  wire logic        normal_in,
  input  wire logic        fitted_in,
  output logic             switch_normal_out,
  output logic             jumper_fitted_out,
  output logic [15:0]      high_len_out,
  output logic [15:0]      low_len_out,
  output logic [7:0]       edges_out
);
  logic        lamp_q;
  logic [15:0] run_q;
  assign switch_normal_out = normal_in;
  assign jumper_fitted_out = fitted_in;
  // Length of last whole lit and dark run
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      lamp_q       <= 1'b0;
      run_q        <= 16'h0;
      high_len_out <= 16'h0;
      low_len_out  <= 16'h0;
      edges_out    <= 8'h0;
    end
    else if (lamp_in != lamp_q)
    begin
      if (lamp_q)
        high_len_out <= run_q;
      else
        low_len_out <= run_q;
      lamp_q    <= lamp_in;
      run_q     <= 16'h1;
      edges_out <= edges_out + 8'h1;
    end
    else
      run_q <= run_q + 16'h1;
  end
endmodule

// >>> verification/test_gateway_status_indicator_ctrl.sv
/* Bench for the gateway status block: modes, lamps, watchdog, registers.
   Drives the design and a panel model; ms timing shortened to 10 cycles. */
`timescale 1ns/1ns
module test_gateway_status_indicator_ctrl;
  localparam int unsigned MS  = 10;
  localparam logic [7:0]  TMO = gateway_status_pkg::WDT_TIMEOUT_ADDR;
  localparam logic [7:0]  SVC = gateway_status_pkg::WDT_SERVICE_ADDR;
  localparam logic [7:0]  STS = gateway_status_pkg::STATUS_ADDR;
  logic        clk, rst, norm_sel, fit_sel, sw, jmp, fatal, bus_off, tx_fail, addr_fail, can_act, ser_act;
  logic        awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic        pwr, can_l, ser_l, upd, op, cmd, boot;
  logic [1:0]  bresp, rresp, resp;
  logic [2:0]  if_en;
  logic [3:0]  strb;
  logic [7:0]  awaddr, araddr, edges, e;
  logic [15:0] hi, lo;
  logic [31:0] wdata, rdata, data;
  int          bad_count, n_checks, boots, n, lit;

  gateway_status_ctrl #(.MS_CYCLES(MS)) u_dut (
    .CORE_CLK_IN(clk), .RST_IN(rst), .MODE_SWITCH_NORMAL_IN(sw), .WATCHDOG_ENABLE_JUMPER_IN(jmp),
    .FATAL_FAULT_IN(fatal), .CAN_BUS_OFF_IN(bus_off), .CAN_TX_FAIL_IN(tx_fail), .ADDR_CLAIM_FAIL_IN(addr_fail),
    .CAN_ACTIVITY_IN(can_act), .SERIAL_ACTIVITY_IN(ser_act), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(strb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .POWER_ERROR_LAMP_OUT(pwr),
    .CAN_ACTIVITY_LAMP_OUT(can_l), .SERIAL_ACTIVITY_LAMP_OUT(ser_l), .UPDATE_MODE_OUT(upd),
    .OPERATION_MODE_OUT(op), .SERIAL_CMD_ENABLE_OUT(cmd), .SERIAL_IF_ENABLE_OUT(if_en), .WARM_BOOT_OUT(boot));

  lamp_panel_model u_panel (.clk_in(clk), .rst_in(rst), .lamp_in(pwr), .normal_in(norm_sel), .fitted_in(fit_sel),
    .switch_normal_out(sw), .jumper_fitted_out(jmp), .high_len_out(hi), .low_len_out(lo), .edges_out(edges));

  always #50 clk = ~clk;
  always @(posedge clk)
    if (boot === 1'b1)
      boots++;

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    data = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  // Lit and dark halves of the power lamp
  task automatic meas(input int half);
    cyc(3);
    e = edges + 8'h03;
    while (edges !== e)
      @(posedge clk);
    chk({16'h0, hi}, 32'(half * MS));
    chk({16'h0, lo}, 32'(half * MS));
  endtask
  task automatic steady();
    cyc(3);
    e = edges;
    cyc(600);
    chk({31'h0, pwr}, 32'h1);
    chk({24'h0, edges}, {24'h0, e});
  endtask
  task automatic poke(input int i);
    if (i == 1) ser_act <= 1'b1;
    else can_act <= 1'b1;
    @(posedge clk);
    ser_act <= 1'b0;
    can_act <= 1'b0;
  endtask

  initial
  begin
    clk = 0; rst = 1; norm_sel = 1; fit_sel = 1; fatal = 0; bus_off = 0; tx_fail = 0; addr_fail = 0;
    can_act = 0; ser_act = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; strb = 4'hf; bad_count = 0; n_checks = 0;
    cyc(3);
    chk({29'h0, pwr, can_l, ser_l}, 32'h0);
    chk({29'h0, if_en}, 32'h7);
    rst <= 1'b0;
    cyc(10);
    chk({29'h0, upd, op, cmd}, 32'h3);
    norm_sel <= 1'b0;
    cyc(10);
    chk({29'h0, upd, op, cmd}, 32'h3);
    rd(TMO);
    chk(data, {16'h0, gateway_status_pkg::WDT_TIMEOUT_RESET});
    rd(8'h0c);
    chk({30'h0, resp}, 32'h2);
    chk(data, 32'h0);
    wr(8'h10, 32'h5);
    chk({30'h0, resp}, 32'h2);
    wr(TMO, 32'h3);
    wr(SVC, 32'h0);
    n = 0;
    while (boot !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(n > 4 && n < 46), 32'h1);
    rd(STS);
    chk(data, 32'he);
    meas(500);
    chk({31'h0, ser_l}, {31'h0, pwr});
    fit_sel <= 1'b0;
    cyc(10);
    wr(STS, 32'h8);
    rd(STS);
    chk(data, 32'h2);
    rd(SVC);
    chk(data, 32'h0);
    strb <= 4'h1;
    wr(TMO, 32'h1234);
    rd(TMO);
    chk(data, 32'h34);
    strb <= 4'hf;
    n = boots;
    steady();
    addr_fail <= 1'b1;
    meas(500);
    tx_fail <= 1'b1;
    meas(50);
    bus_off <= 1'b1;
    meas(250);
    rd(STS);
    chk(data, 32'h72);
    fatal <= 1'b1;
    meas(50);
    fatal <= 1'b0;
    bus_off <= 1'b0;
    tx_fail <= 1'b0;
    addr_fail <= 1'b0;
    steady();
    for (int i = 0; i < 2; i++)
    begin
      lit = 0;
      poke(i);
      for (int c = 0; c < 1200; c++)
      begin
        if (c == 600) poke(i);
        else @(posedge clk);
        lit = lit + ((((i == 1) ? ser_l : can_l) === 1'b1) ? 1 : 0);
      end
      // One 50 ms lit half; the second event falls inside the blink and is ignored
      chk(32'(lit >= 490 && lit <= 500), 32'h1);
      chk({31'h0, (i == 1) ? ser_l : can_l}, 32'h0);
    end
    chk(32'(boots), 32'(n));
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    cyc(10);
    chk({29'h0, upd, op, cmd}, 32'h4);
    bus_off <= 1'b1;
    e = edges;
    cyc(600);
    chk({21'h0, pwr, can_l, ser_l, edges}, {21'h0, 3'h7, e});
    norm_sel <= 1'b1;
    cyc(10);
    chk({29'h0, upd, op, cmd}, 32'h4);
    end_of_test();
  end

  initial
  begin
    cyc(100000);
    bad_count++;
    end_of_test();
  end
endmodule
